// ==== rtl/motor_sense_pkg.sv ====
package motor_sense_pkg;
   // ****************************************
   // Widths and sizes
   // ****************************************
   localparam int ADC_W     = 12;
   localparam int VOLT_W    = 16;
   localparam int EXP_MAX   = 15;
   localparam int ACC_W     = ADC_W + EXP_MAX;
   localparam int DIV_STEPS = 24;
   localparam int NPH       = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [3:0]  EXP_RST     = 4'hD;
   localparam logic [15:0] PRECHG_RST  = 16'h0064;
   localparam logic [15:0] PWM_PER_RST = 16'h30D4;
   localparam logic [15:0] VLIM_RST    = 16'h4000;
   localparam logic [2:0]  CFG_RST     = 3'h2;
   localparam logic [23:0] RECIP_RST   = 24'h001000;

   // ****************************************
   // Arithmetic constants
   // ****************************************
   localparam logic [23:0] RECIP_NUM   = 24'h800000;
   localparam logic [15:0] THIRD_MUL   = 16'h5556;
   localparam logic [4:0]  RECIP_SHIFT = 5'h0C;
   localparam logic [4:0]  HALF_SHIFT  = 5'h0B;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CFG_COMP_BIT   = 0;
   localparam int CFG_RERUN_BIT  = 1;
   localparam int CFG_SHUNT_BIT  = 2;
   localparam int CMD_RECAL_BIT  = 1;
   localparam int STAT_CAL_BIT   = 0;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_PRE_BIT   = 2;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] OFS_SYSCFG = 12'h000;
   localparam logic [11:0] OFS_CMD    = 12'h004;
   localparam logic [11:0] OFS_EXP    = 12'h008;
   localparam logic [11:0] OFS_PRECHG = 12'h00C;
   localparam logic [11:0] OFS_PWMPER = 12'h010;
   localparam logic [11:0] OFS_VLIM   = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;
   localparam logic [11:0] OFS_OFS0   = 12'h01C;
   localparam logic [11:0] OFS_OFS1   = 12'h020;
   localparam logic [11:0] OFS_OFS2   = 12'h024;
   localparam logic [11:0] OFS_VMAG   = 12'h028;
   localparam logic [11:0] OFS_VDC    = 12'h02C;
   localparam logic [11:0] OFS_MINUM  = 12'h030;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 8;
   localparam int VMAG_PERIOD_NS = 1000000;
   localparam int VMAG_CYCLES    = VMAG_PERIOD_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic signed [15:0] alpha;
      logic signed [15:0] beta;
   } ab_volt_t;
endpackage : motor_sense_pkg

// ==== rtl/motor_sense_offset_precharge_dcbus.sv ====
`timescale 1ns/1ps
module motor_sense_offset_precharge_dcbus #(
   parameter int VMAG_CYCLES = motor_sense_pkg::VMAG_CYCLES
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       pwm_cycle_start,
   input  wire logic [11:0]                phase_u_current_input,
   input  wire logic [11:0]                phase_v_current_input,
   input  wire logic [11:0]                phase_w_current_input,
   input  wire logic [11:0]                shunt_current_input,
   input  wire logic [11:0]                bus_voltage_in,
   input  wire logic                       drive_stopped,
   input  wire logic                       fault_cleared,
   input  wire logic                       precharge_start,
   input  wire motor_sense_pkg::ab_volt_t  v_cmd,
   input  wire logic signed [15:0]         v_d,
   input  wire logic signed [15:0]         v_q,
   output logic                            offset_calibration_state,
   output logic                            offset_cal_done,
   output logic                            precharge_state,
   output logic                            precharge_done,
   output logic      [2:0]                 low_side_on,
   output motor_sense_pkg::ab_volt_t       mod_out,
   output motor_sense_pkg::ab_volt_t       flux_volt,
   output logic      [15:0]                vector_limit_out,
   output logic      [15:0]                motor_voltage_magnitude
);
   localparam int NPH   = motor_sense_pkg::NPH;
   localparam int ACC_W = motor_sense_pkg::ACC_W;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic signed [15:0] scale_sat(
      input logic signed [15:0] v,
      input logic [23:0]        k,
      input logic [4:0]         sh);
      logic signed [40:0] p;
      p = (v * $signed({1'b0, k})) >>> sh;
      if (p > 41'sh00000007FFF)
         return 16'sh7FFF;
      else if (p < -41'sh00000008000)
         return -16'sh8000;
      else
         return p[15:0];
   endfunction : scale_sat

   function automatic logic [15:0] isqrt(input logic [31:0] x);
      logic [15:0] q;
      logic [15:0] c;
      q = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         c = q | (16'h0001 << i);
         if (32'(c) * 32'(c) <= x)
            q = c;
      end
      return q;
   endfunction : isqrt

   // ****************************************
   // Register bus
   // ****************************************
   logic [2:0]  syscfg_r;
   logic [3:0]  exp_r;
   logic [15:0] prechg_cnt_r;
   logic [15:0] pwm_per_r;
   logic [15:0] vlim_r;
   logic        valid_r;
   logic [11:0] offset_r [NPH];
   logic [11:0] vdc_r;
   logic [15:0] mi_num_r;
   logic        wr_en;
   logic        recal_req;
   logic        addr_hit;
   logic [31:0] rd_val;
   logic        comp;

   assign wr_en     = psel & penable & pwrite;
   assign recal_req = wr_en && paddr == motor_sense_pkg::OFS_CMD &&
                      pwdata[motor_sense_pkg::CMD_RECAL_BIT] &&
                      drive_stopped;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~addr_hit;
   assign comp      = syscfg_r[motor_sense_pkg::CFG_COMP_BIT];

   always_comb begin
      addr_hit = 1'b1;
      rd_val   = 32'h00000000;
      unique case (paddr)
         motor_sense_pkg::OFS_SYSCFG: rd_val[2:0]  = syscfg_r;
         motor_sense_pkg::OFS_CMD:    rd_val       = 32'h00000000;
         motor_sense_pkg::OFS_EXP:    rd_val[3:0]  = exp_r;
         motor_sense_pkg::OFS_PRECHG: rd_val[15:0] = prechg_cnt_r;
         motor_sense_pkg::OFS_PWMPER: rd_val[15:0] = pwm_per_r;
         motor_sense_pkg::OFS_VLIM:   rd_val[15:0] = vlim_r;
         motor_sense_pkg::OFS_STATUS: rd_val[2:0]  =
            {precharge_state, valid_r, offset_calibration_state};
         motor_sense_pkg::OFS_OFS0:   rd_val[11:0] = offset_r[0];
         motor_sense_pkg::OFS_OFS1:   rd_val[11:0] = offset_r[1];
         motor_sense_pkg::OFS_OFS2:   rd_val[11:0] = offset_r[2];
         motor_sense_pkg::OFS_VMAG:   rd_val[15:0] = motor_voltage_magnitude;
         motor_sense_pkg::OFS_VDC:    rd_val[11:0] = vdc_r;
         motor_sense_pkg::OFS_MINUM:  rd_val[15:0] = mi_num_r;
         default:                     addr_hit     = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_val;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syscfg_r     <= motor_sense_pkg::CFG_RST;
         exp_r        <= motor_sense_pkg::EXP_RST;
         prechg_cnt_r <= motor_sense_pkg::PRECHG_RST;
         pwm_per_r    <= motor_sense_pkg::PWM_PER_RST;
         vlim_r       <= motor_sense_pkg::VLIM_RST;
      end else if (wr_en) begin
         unique case (paddr)
            motor_sense_pkg::OFS_SYSCFG: syscfg_r     <= pwdata[2:0];
            motor_sense_pkg::OFS_EXP:    exp_r        <= pwdata[3:0];
            motor_sense_pkg::OFS_PRECHG: prechg_cnt_r <= pwdata[15:0];
            motor_sense_pkg::OFS_PWMPER: pwm_per_r    <= pwdata[15:0];
            motor_sense_pkg::OFS_VLIM:   vlim_r       <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Offset calibration
   // ****************************************
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN  = 2'b10
   } cal_state_t;

   cal_state_t        cal_st_r;
   logic              need_cal_r;
   logic [3:0]        exp_run_r;
   logic [15:0]       cal_cnt_r;
   logic [ACC_W-1:0]  acc_r  [NPH];
   logic [ACC_W-1:0]  acc_nxt[NPH];
   logic [11:0]       samp   [NPH];
   logic              cal_start;
   logic              cal_last;

   assign offset_calibration_state = (cal_st_r == CAL_RUN);
   assign cal_start = cal_st_r == CAL_IDLE && need_cal_r &&
                      drive_stopped && !precharge_state;
   assign cal_last  = offset_calibration_state && pwm_cycle_start &&
                      cal_cnt_r + 16'h0001 == (16'h0001 << exp_run_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         need_cal_r <= 1'b1;
      else if (recal_req ||
               (fault_cleared &&
                syscfg_r[motor_sense_pkg::CFG_RERUN_BIT]))
         need_cal_r <= 1'b1;
      else if (cal_start)
         need_cal_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_st_r        <= CAL_IDLE;
         exp_run_r       <= 4'h0;
         cal_cnt_r       <= 16'h0000;
         offset_cal_done <= 1'b0;
      end else begin
         offset_cal_done <= 1'b0;
         unique case (cal_st_r)
            CAL_IDLE: if (cal_start) begin
               cal_st_r  <= CAL_RUN;
               exp_run_r <= exp_r;
               cal_cnt_r <= 16'h0000;
            end
            CAL_RUN: if (cal_last) begin
               cal_st_r        <= CAL_IDLE;
               offset_cal_done <= 1'b1;
            end else if (pwm_cycle_start) begin
               cal_cnt_r <= cal_cnt_r + 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         valid_r <= 1'b0;
      else if (cal_last)
         valid_r <= 1'b1;
   end

   for (genvar g = 0; g < NPH; g++) begin : g_phase
      logic [11:0] leg;
      assign leg = (g == 0) ? phase_u_current_input :
                   (g == 1) ? phase_v_current_input :
                              phase_w_current_input;
      assign samp[g] = syscfg_r[motor_sense_pkg::CFG_SHUNT_BIT] ?
                       shunt_current_input : leg;
      assign acc_nxt[g] = acc_r[g] + ACC_W'(samp[g]);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            acc_r[g]    <= '0;
            offset_r[g] <= 12'h000;
         end else if (cal_start) begin
            acc_r[g] <= '0;
         end else if (offset_calibration_state && pwm_cycle_start) begin
            acc_r[g] <= acc_nxt[g];
            if (cal_last)
               offset_r[g] <= 12'(acc_nxt[g] >> exp_run_r);
         end
      end
   end

   // ****************************************
   // Bootstrap pre-charge
   // ****************************************
   typedef enum logic [1:0] {
      PC_IDLE = 2'b01,
      PC_RUN  = 2'b10
   } pc_state_t;

   pc_state_t   pc_st_r;
   logic        pc_go_r;
   logic [15:0] pc_cycles_r;
   logic [15:0] sub_r;
   logic [31:0] third_prod;
   logic [15:0] third;
   logic [2:0]  phase_sel;

   assign precharge_state = (pc_st_r == PC_RUN);
   assign third_prod = 32'(pwm_per_r) * 32'(motor_sense_pkg::THIRD_MUL);
   assign third      = third_prod[31:16];

   always_comb begin
      if (sub_r < third)
         phase_sel = 3'h1;
      else if (sub_r < {third[14:0], 1'b0})
         phase_sel = 3'h2;
      else
         phase_sel = 3'h4;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sub_r <= 16'h0000;
      else if (pwm_cycle_start)
         sub_r <= 16'h0000;
      else if (sub_r != 16'hFFFF)
         sub_r <= sub_r + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_st_r        <= PC_IDLE;
         pc_go_r        <= 1'b0;
         pc_cycles_r    <= 16'h0000;
         precharge_done <= 1'b0;
      end else begin
         precharge_done <= 1'b0;
         unique case (pc_st_r)
            PC_IDLE: if (precharge_start && !offset_calibration_state) begin
               pc_st_r     <= PC_RUN;
               pc_go_r     <= 1'b0;
               pc_cycles_r <= 16'h0000;
            end
            PC_RUN: if (pwm_cycle_start) begin
               pc_go_r <= 1'b1;
               if (pc_go_r)
                  pc_cycles_r <= pc_cycles_r + 16'h0001;
               if ((pc_go_r &&
                    pc_cycles_r + 16'h0001 == prechg_cnt_r) ||
                   (!pc_go_r && prechg_cnt_r == 16'h0000)) begin
                  pc_st_r        <= PC_IDLE;
                  precharge_done <= 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         low_side_on <= 3'h0;
      else if (precharge_state && pc_go_r && !offset_calibration_state)
         low_side_on <= phase_sel;
      else
         low_side_on <= 3'h0;
   end

   // ****************************************
   // Bus voltage and reciprocal
   // ****************************************
   logic [23:0] num_r;
   logic [11:0] rem_r;
   logic [23:0] quo_r;
   logic [23:0] recip_r;
   logic [4:0]  div_cnt_r;
   logic [12:0] rem_sh;
   logic [12:0] rem_sub;
   logic        div_ge;

   assign rem_sh  = {rem_r, num_r[23]};
   assign div_ge  = rem_sh >= {1'b0, vdc_r};
   assign rem_sub = rem_sh - {1'b0, vdc_r};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vdc_r     <= 12'h000;
         num_r     <= 24'h000000;
         rem_r     <= 12'h000;
         quo_r     <= 24'h000000;
         recip_r   <= motor_sense_pkg::RECIP_RST;
         div_cnt_r <= 5'h00;
      end else if (pwm_cycle_start) begin
         vdc_r     <= bus_voltage_in;
         num_r     <= motor_sense_pkg::RECIP_NUM;
         rem_r     <= 12'h000;
         quo_r     <= 24'h000000;
         div_cnt_r <= 5'(motor_sense_pkg::DIV_STEPS);
      end else if (div_cnt_r != 5'h00) begin
         rem_r     <= div_ge ? rem_sub[11:0] : rem_sh[11:0];
         num_r     <= {num_r[22:0], 1'b0};
         quo_r     <= {quo_r[22:0], div_ge};
         div_cnt_r <= div_cnt_r - 5'h01;
         if (div_cnt_r == 5'h01)
            recip_r <= {quo_r[22:0], div_ge};
      end
   end

   // ****************************************
   // Compensation
   // ****************************************
   logic [27:0] vlim_prod;

   assign vlim_prod = 28'(vlim_r) * 28'(vdc_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_out          <= '0;
         flux_volt        <= '0;
         vector_limit_out <= 16'h0000;
      end else if (comp) begin
         mod_out.alpha <= scale_sat(v_cmd.alpha, recip_r,
                                    motor_sense_pkg::RECIP_SHIFT);
         mod_out.beta  <= scale_sat(v_cmd.beta, recip_r,
                                    motor_sense_pkg::RECIP_SHIFT);
         flux_volt <= v_cmd;
         vector_limit_out <= (vlim_prod[27:11] > 17'h0FFFF) ? 16'hFFFF :
                             vlim_prod[26:11];
      end else begin
         mod_out <= v_cmd;
         flux_volt.alpha <= scale_sat(v_cmd.alpha, {12'h000, vdc_r},
                                      motor_sense_pkg::HALF_SHIFT);
         flux_volt.beta  <= scale_sat(v_cmd.beta, {12'h000, vdc_r},
                                      motor_sense_pkg::HALF_SHIFT);
         vector_limit_out <= vlim_r;
      end
   end

   // ****************************************
   // Motor voltage magnitude
   // ****************************************
   logic [16:0]        vmag_cnt_r;
   logic               vmag_tick;
   logic signed [31:0] sq_d;
   logic signed [31:0] sq_q;
   logic [31:0]        sq_sum;
   logic [39:0]        mi_prod;

   assign vmag_tick = vmag_cnt_r == 17'(VMAG_CYCLES - 1);
   assign sq_d      = v_d * v_d;
   assign sq_q      = v_q * v_q;
   assign sq_sum    = $unsigned(sq_d) + $unsigned(sq_q);
   assign mi_prod   = 40'(motor_voltage_magnitude) * 40'(recip_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         vmag_cnt_r <= 17'h00000;
      else if (vmag_tick)
         vmag_cnt_r <= 17'h00000;
      else
         vmag_cnt_r <= vmag_cnt_r + 17'h00001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         motor_voltage_magnitude <= 16'h0000;
      else if (vmag_tick)
         motor_voltage_magnitude <= isqrt(sq_sum);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mi_num_r <= 16'h0000;
      else if (!comp)
         mi_num_r <= motor_voltage_magnitude;
      else if (mi_prod[39:12] > 28'h000FFFF)
         mi_num_r <= 16'hFFFF;
      else
         mi_num_r <= mi_prod[27:12];
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [16:0] h_pwm_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         h_pwm_r <= 17'h00000;
      else if (cal_start)
         h_pwm_r <= 17'h00000;
      else if (offset_calibration_state && pwm_cycle_start)
         h_pwm_r <= h_pwm_r + 17'h00001;
   end

   cal_gates_off_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      offset_calibration_state |-> low_side_on == 3'h0)
      else $error("gates on during calibration");
   cal_length_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      offset_cal_done |-> h_pwm_r == (17'h00001 << exp_run_r))
      else $error("calibration sample count wrong");
   // A pending request may legally restart calibration at once
   cal_return_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      offset_cal_done && !need_cal_r |-> !offset_calibration_state ##1
      !offset_calibration_state)
      else $error("calibration did not end");
   rerun_off_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      fault_cleared && !syscfg_r[motor_sense_pkg::CFG_RERUN_BIT] &&
      !recal_req && !need_cal_r |=> !need_cal_r)
      else $error("offsets recalculated with rerun off");
   recal_stop_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      cal_start |-> drive_stopped && !precharge_state)
      else $error("calibration started while not stopped");
   prechg_onehot_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      low_side_on != 3'h0 |-> $onehot0(low_side_on) &&
      $past(precharge_state))
      else $error("more than one low side on");
   prechg_order_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      low_side_on == 3'h2 |-> $past(low_side_on) inside {3'h1, 3'h2})
      else $error("pre-charge phase order broken");
   // Attempt at the release edge would see reset-valued outputs
   pass_through_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      presetn && !comp |=> mod_out == $past(v_cmd) &&
      vector_limit_out == $past(vlim_r))
      else $error("uncompensated command altered");
   flux_plain_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      comp |=> flux_volt == $past(v_cmd))
      else $error("flux voltage corrected while compensating");
   vmag_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !vmag_tick |=> $stable(motor_voltage_magnitude))
      else $error("magnitude changed between updates");
endmodule : motor_sense_offset_precharge_dcbus

// ==== testbench/adc_gate_model.sv ====
`timescale 1ns/1ps
module adc_gate_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] lvl,
   input  wire logic [2:0]  low_side_on,
   output logic             pwm_cycle_start,
   output logic [11:0]      phase_u_current_input,
   output logic [11:0]      phase_v_current_input,
   output logic [11:0]      phase_w_current_input,
   output logic [11:0]      shunt_current_input
);
   localparam logic [7:0] PER = 8'h1E;
   logic [7:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 8'h00;
      else if (cnt_r == PER - 8'h01) cnt_r <= 8'h00;
      else cnt_r <= cnt_r + 8'h01;
   end
   assign pwm_cycle_start = presetn && cnt_r == 8'h00;
   // Closed low side lets current reach its shunt
   assign phase_u_current_input = lvl + {3'h0, low_side_on[0], 8'h00};
   assign phase_v_current_input = lvl + {3'h0, low_side_on[1], 8'h01};
   assign phase_w_current_input = lvl + {3'h0, low_side_on[2], 8'h02};
   assign shunt_current_input = lvl + {3'h0, |low_side_on, 8'h03};
endmodule : adc_gate_model

// ==== testbench/test_motor_sense_offset_precharge_dcbus.sv ====
`timescale 1ns/1ps
module test_motor_sense_offset_precharge_dcbus;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic pwm_cycle_start, drive_stopped, fault_cleared, precharge_start;
   logic offset_calibration_state, offset_cal_done, precharge_state;
   logic precharge_done;
   logic [11:0] paddr, phase_u_current_input, phase_v_current_input;
   logic [11:0] phase_w_current_input, shunt_current_input;
   logic [11:0] bus_voltage_in, lvl;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] low_side_on, first;
   logic signed [15:0] v_d, v_q;
   logic [15:0] vector_limit_out, motor_voltage_magnitude;
   motor_sense_pkg::ab_volt_t v_cmd, mod_out, flux_volt;
   int fails, cmp_count, cyc, multi, pd;
   int n[3] = '{0, 0, 0};
   motor_sense_offset_precharge_dcbus #(.VMAG_CYCLES(50))
   i_motor_sense_offset_precharge_dcbus (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_cycle_start,
      .phase_u_current_input, .phase_v_current_input, .phase_w_current_input,
      .shunt_current_input, .bus_voltage_in, .drive_stopped, .fault_cleared,
      .precharge_start, .v_cmd, .v_d, .v_q, .offset_calibration_state,
      .offset_cal_done, .precharge_state, .precharge_done, .low_side_on,
      .mod_out, .flux_volt, .vector_limit_out, .motor_voltage_magnitude);
   adc_gate_model i_adc_gate_model (.pclk, .presetn, .lvl, .low_side_on,
      .pwm_cycle_start, .phase_u_current_input, .phase_v_current_input,
      .phase_w_current_input, .shunt_current_input);
   task automatic results;
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wdone;
      do @(negedge pclk); while (offset_cal_done !== 1'b1);
   endtask : wdone
   task automatic ofs(input logic [31:0] e, input logic [31:0] s);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, motor_sense_pkg::OFS_OFS0 + 12'(4 * i), 32'h0);
         chk(rd, e + s * i);
      end
   endtask : ofs
   task automatic comp(input logic [31:0] c, m, f, l, mi);
      xfer(1'b1, motor_sense_pkg::OFS_SYSCFG, c);
      repeat (100) @(negedge pclk);
      chk(mod_out, m);
      chk(flux_volt, f);
      chk(vector_limit_out, l);
      chk(motor_voltage_magnitude, 32'h1F4);
      xfer(1'b0, motor_sense_pkg::OFS_MINUM, 32'h0);
      chk(rd, mi);
   endtask : comp
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, drive_stopped, first} = '0;
      {fault_cleared, precharge_start, paddr, pwdata} = '0;
      lvl = 12'h123;
      bus_voltage_in = 12'h400;
      v_cmd = 32'h03E8FE0C;
      v_d = 16'sh012C;
      v_q = 16'sh0190;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, motor_sense_pkg::OFS_EXP, 32'h0);
      chk(rd, 32'hD);
      xfer(1'b1, motor_sense_pkg::OFS_EXP, 32'h2);
      xfer(1'b1, motor_sense_pkg::OFS_PWMPER, 32'h1E);
      xfer(1'b1, motor_sense_pkg::OFS_PRECHG, 32'h3);
      drive_stopped <= 1'b1;
      wdone();
      @(negedge pclk);
      chk(offset_calibration_state, 32'h0);
      ofs(32'h123, 32'h1);
      xfer(1'b0, 12'h040, 32'h0);
      chk(er, 32'h1);
      xfer(1'b1, motor_sense_pkg::OFS_SYSCFG, 32'h6);
      lvl <= 12'h200;
      xfer(1'b1, motor_sense_pkg::OFS_CMD, 32'h2);
      wdone();
      ofs(32'h203, 32'h0);
      for (int r = 0; r < 2; r++) begin
         xfer(1'b1, motor_sense_pkg::OFS_SYSCFG, 32'(2 * r));
         fault_cleared <= 1'b1;
         @(posedge pclk);
         fault_cleared <= 1'b0;
         repeat (3) @(negedge pclk);
         chk(offset_calibration_state, 32'(r));
      end
      wdone();
      @(posedge pclk);
      precharge_start <= 1'b1;
      @(posedge pclk);
      precharge_start <= 1'b0;
      @(negedge pclk);
      chk(precharge_state, 32'h1);
      repeat (140) begin
         @(negedge pclk);
         if (first == 3'h0) first = low_side_on;
         if ($countones(low_side_on) > 1) multi++;
         for (int i = 0; i < 3; i++) n[i] += low_side_on[i];
         pd += precharge_done;
      end
      chk(first, 32'h1);
      chk(multi, 32'h0);
      chk(pd, 32'h1);
      for (int i = 0; i < 3; i++) chk(n[i], 32'h1E);
      comp(32'h3, 32'h07D0FC18, 32'h03E8FE0C, 32'h2000, 32'h3E8);
      xfer(1'b0, motor_sense_pkg::OFS_VDC, 32'h0);
      chk(rd, 32'h400);
      comp(32'h2, 32'h03E8FE0C, 32'h01F4FF06, 32'h4000, 32'h1F4);
      results();
   end
endmodule : test_motor_sense_offset_precharge_dcbus
